// ==== cvm_pkg.sv ====
// ************************************************************
// Constants shared by the case selector and value decoder.
// ************************************************************
package cvm_pkg;

  // ************************************************************
  // Register bus layout.
  // ************************************************************
  localparam int CVM_AXI_AW = 8;
  localparam logic [7:0] CVM_OFF_CTRL = 8'h00;
  localparam logic [7:0] CVM_OFF_SW_SEL = 8'h04;
  localparam logic [7:0] CVM_OFF_SW_DEC = 8'h08;
  localparam logic [7:0] CVM_OFF_CASE_STAT = 8'h0c;
  localparam logic [7:0] CVM_OFF_MISC_STAT = 8'h10;
  localparam int CVM_CTRL_SRC_BIT = 0;
  localparam int CVM_MISC_DFLT_BIT = 0;
  localparam int CVM_MISC_MATCH_BIT = 1;
  localparam logic CVM_CTRL_SRC_RST = 1'h0;
  localparam logic [31:0] CVM_WORD_RST = 32'h0000_0000;
  localparam logic [1:0] CVM_RESP_OKAY = 2'h0;
  localparam logic [1:0] CVM_RESP_SLVERR = 2'h2;

  // ************************************************************
  // Number formats of the value decoder input.
  // ************************************************************
  localparam int CVM_FMT_SINT = 0;
  localparam int CVM_FMT_SFRAC = 1;
  localparam int CVM_FMT_UINT = 2;

endpackage

// ==== cvm_case_decoder.sv ====
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module cvm_case_decoder
  import cvm_pkg::*;
#(
  parameter int NUM_CASES = 4,
  parameter int MAX_ALTS = 3,
  parameter int CASE_ALTS [NUM_CASES] = '{3, 1, 2, 1},
  parameter int CASE_VALS [NUM_CASES][MAX_ALTS] =
    '{'{1, 2, 3}, '{4, 0, 0}, '{5, -1, 0}, '{7, 0, 0}},
  parameter bit SEL_SIGNED = 1'b1,
  parameter int SEL_L = 8,
  parameter bit PIPELINE = 1'b0,
  parameter bit DEFAULT_EN = 1'b1,
  parameter int DEC_FMT = CVM_FMT_UINT,
  parameter int DEC_L = 2,
  parameter int DEC_R = 0,
  parameter bit DEC_REG = 1'b0,
  parameter longint DEC_VALUE = 5,
  localparam int DEC_RE = (DEC_FMT == CVM_FMT_SFRAC) ? DEC_R : 0,
  localparam int DEC_W = DEC_L + DEC_RE
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CVM_AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [CVM_AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [SEL_L-1:0] sel_in,
  output logic [NUM_CASES-1:0] case_out,
  output logic case_dflt,
  input wire logic [DEC_W-1:0] dec_in,
  output logic dec_match
);

  // ************************************************************
  // Elaboration checks.
  // ************************************************************
  if (NUM_CASES < 1 || NUM_CASES > 32) begin : g_bad_cases
    $error("NUM_CASES must lie in 1..32");
  end
  if (MAX_ALTS < 1) begin : g_bad_alts
    $error("MAX_ALTS must be at least 1");
  end
  if (SEL_L < 1 || SEL_L > 32) begin : g_bad_sel
    $error("SEL_L must lie in 1..32");
  end
  if (DEC_FMT < CVM_FMT_SINT || DEC_FMT > CVM_FMT_UINT) begin : g_bad_fmt
    $error("DEC_FMT is not a known format");
  end
  if (DEC_L < 0 || DEC_R < 0 || DEC_W < 1 || DEC_W > 32) begin : g_bad_dec
    $error("Decoder width must lie in 1..32");
  end
  for (genvar gi = 0; gi < NUM_CASES; gi++) begin : g_chk
    // Every case needs a real alternative, so an empty trailing entry
    // can never turn into an extra output.
    if (CASE_ALTS[gi] < 1 || CASE_ALTS[gi] > MAX_ALTS) begin : g_bad
      $error("Each case needs 1..MAX_ALTS alternatives");
    end
  end

  // ************************************************************
  // Functions.
  // ************************************************************
  function automatic logic [NUM_CASES-1:0] cvm_case_hits(
    input logic [SEL_L-1:0] v
  );
    logic signed [32:0] x;
    logic signed [32:0] c;
    logic [NUM_CASES-1:0] h;
    h = '0;
    // The MSB extends as a sign only for a signed bus.
    x = {{(33-SEL_L){SEL_SIGNED & v[SEL_L-1]}}, v};
    for (int i = 0; i < NUM_CASES; i++) begin
      for (int j = 0; j < MAX_ALTS; j++) begin
        c = 33'(signed'(CASE_VALS[i][j]));
        if (j < CASE_ALTS[i] && x == c) begin
          h[i] = 1'b1;
        end
      end
    end
    return h;
  endfunction

  function automatic logic [31:0] cvm_wmask(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  localparam logic [DEC_W-1:0] DEC_CODE = DEC_VALUE[DEC_W-1:0];

  // ************************************************************
  // State.
  // ************************************************************
  typedef struct packed {
    logic [NUM_CASES-1:0] case_r;
    logic dflt_r;
    logic match_r;
    logic src;
    logic [SEL_L-1:0] sw_sel;
    logic [DEC_W-1:0] sw_dec;
    logic aw_full;
    logic [CVM_AXI_AW-1:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cvm_state_t;

  cvm_state_t st_q;
  cvm_state_t st_d;
  logic [SEL_L-1:0] sel_src;
  logic [DEC_W-1:0] dec_src;
  logic [NUM_CASES-1:0] hits;
  logic dflt_c;
  logic match_c;
  logic [CVM_AXI_AW-1:0] wa;

  // ************************************************************
  // Datapath.
  // ************************************************************
  assign sel_src = st_q.src ? st_q.sw_sel : sel_in;
  assign dec_src = st_q.src ? st_q.sw_dec : dec_in;
  assign hits = cvm_case_hits(sel_src);
  assign dflt_c = DEFAULT_EN & ~(|hits);
  assign match_c = (dec_src == DEC_CODE);

  assign case_out = PIPELINE ? st_q.case_r : hits;
  assign case_dflt = PIPELINE ? st_q.dflt_r : dflt_c;
  assign dec_match = DEC_REG ? st_q.match_r : match_c;

  assign s_axi_awready = ~st_q.aw_full;
  assign s_axi_wready = ~st_q.w_full;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = ~st_q.rvalid;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign wa = {st_q.awaddr[CVM_AXI_AW-1:2], 2'b00};

  // ************************************************************
  // Next state.
  // ************************************************************
  always_comb begin
    st_d = st_q;
    // Output registers follow the inputs every edge, untouched by reset.
    st_d.case_r = hits;
    st_d.dflt_r = dflt_c;
    st_d.match_r = match_c;

    if (s_axi_awvalid && !st_q.aw_full) begin
      st_d.aw_full = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_full) begin
      st_d.w_full = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    // A write is carried out once both halves are held and the previous
    // response has gone.
    if (st_q.aw_full && st_q.w_full && !st_q.bvalid) begin
      st_d.aw_full = 1'b0;
      st_d.w_full = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = CVM_RESP_OKAY;
      case (wa)
        CVM_OFF_CTRL: begin
          // The source bit lives in byte lane 0, so only that strobe counts.
          st_d.src = st_q.wstrb[0] ? st_q.wdata[CVM_CTRL_SRC_BIT] : st_q.src;
        end
        CVM_OFF_SW_SEL: begin
          st_d.sw_sel = SEL_L'(cvm_wmask(32'(st_q.sw_sel), st_q.wdata,
            st_q.wstrb));
        end
        CVM_OFF_SW_DEC: begin
          st_d.sw_dec = DEC_W'(cvm_wmask(32'(st_q.sw_dec), st_q.wdata,
            st_q.wstrb));
        end
        CVM_OFF_CASE_STAT, CVM_OFF_MISC_STAT: begin
          st_d.bresp = CVM_RESP_OKAY;
        end
        default: begin
          st_d.bresp = CVM_RESP_SLVERR;
        end
      endcase
    end

    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = CVM_RESP_OKAY;
      st_d.rdata = CVM_WORD_RST;
      case ({s_axi_araddr[CVM_AXI_AW-1:2], 2'b00})
        CVM_OFF_CTRL: begin
          st_d.rdata[CVM_CTRL_SRC_BIT] = st_q.src;
        end
        CVM_OFF_SW_SEL: begin
          st_d.rdata = 32'(st_q.sw_sel);
        end
        CVM_OFF_SW_DEC: begin
          st_d.rdata = 32'(st_q.sw_dec);
        end
        CVM_OFF_CASE_STAT: begin
          st_d.rdata = 32'(case_out);
        end
        CVM_OFF_MISC_STAT: begin
          st_d.rdata[CVM_MISC_DFLT_BIT] = case_dflt;
          st_d.rdata[CVM_MISC_MATCH_BIT] = dec_match;
        end
        default: begin
          st_d.rresp = CVM_RESP_SLVERR;
        end
      endcase
    end

    if (!aresetn) begin
      st_d.src = CVM_CTRL_SRC_RST;
      st_d.sw_sel = '0;
      st_d.sw_dec = '0;
      st_d.aw_full = 1'b0;
      st_d.awaddr = '0;
      st_d.w_full = 1'b0;
      st_d.wdata = CVM_WORD_RST;
      st_d.wstrb = '0;
      st_d.bvalid = 1'b0;
      st_d.bresp = CVM_RESP_OKAY;
      st_d.rvalid = 1'b0;
      st_d.rdata = CVM_WORD_RST;
      st_d.rresp = CVM_RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    st_q <= st_d;
  end

endmodule // cvm_case_decoder

// ==== cvm_dp_src.sv ====
`timescale 1ns/1ns
// ****
// Datapath source that feeds integer values to the comparators.
// ****
module cvm_dp_src (
  input wire logic aclk,
  input wire logic ld,
  input wire logic [7:0] nsel,
  input wire logic [1:0] ndec,
  output logic [7:0] sel_in,
  output logic [1:0] dec_in,
  output logic dp_vld
);
  always @(posedge aclk) begin
    sel_in <= nsel;
    dec_in <= ndec;
    dp_vld <= ld;
  end
endmodule // cvm_dp_src

// ==== cvm_case_decoder_asserts.sv ====
`timescale 1ns/1ns
module cvm_chk #(
  parameter int NUM_CASES = 4,
  parameter int SEL_L = 8,
  parameter int DEC_W = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [SEL_L-1:0] sel_in,
  input wire logic [NUM_CASES-1:0] case_out,
  input wire logic case_dflt,
  input wire logic [DEC_W-1:0] dec_in,
  input wire logic dec_match
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  case0_hit_a: assert property (case_out[0] == (sel_in inside {8'h01,
    8'h02, 8'h03})) else $error("case 0 output wrong");
  case1_hit_a: assert property (case_out[1] == (sel_in == 8'h04))
    else $error("case 1 output wrong");
  case2_sign_a: assert property (case_out[2] == (sel_in == 8'h05 ||
    sel_in == 8'hff)) else $error("case 2 output wrong");
  case3_hit_a: assert property (case_out[3] == (sel_in == 8'h07))
    else $error("case 3 output wrong");
  dflt_none_a: assert property (case_dflt == (case_out == 4'h0))
    else $error("default output wrong");
  dec_trunc_a: assert property (dec_match == (dec_in == 2'h1))
    else $error("decoder match wrong");
  case_comb_a: assert property ($changed(sel_in) |->
    $changed(case_out) || case_dflt == $past(case_dflt)) else
    $error("case outputs lag input");
  dec_comb_a: assert property ($stable(dec_in) |-> $stable(dec_match))
    else $error("match moved without input");
  cover property (case_dflt);
  cover property (case_out[2] && sel_in[7]);
  cover property (dec_match);
endmodule // cvm_chk

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import cvm_pkg::*;
  logic aclk = 0, aresetn = 0, ld = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic [7:0] nsel = 0, awaddr = 0, araddr = 0, sel_in;
  logic [1:0] ndec = 0, dec_in, bresp, rresp;
  logic [31:0] wdata = 0, rdata, r;
  logic [3:0] case_out;
  logic case_dflt, dec_match, dp_vld, awready, wready, bvalid, arready, rvalid;
  logic [33:0] bq[$];
  logic [5:0] dq[$];
  logic [7:0] tv[12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'hff, 8'hfe, 8'h80};
  int mismatches = 0, checked = 0, seed = 62486;
  always #5 aclk = ~aclk;
  cvm_dp_src src (.aclk(aclk), .ld(ld), .nsel(nsel), .ndec(ndec),
    .sel_in(sel_in), .dec_in(dec_in), .dp_vld(dp_vld));
  cvm_case_decoder dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .sel_in(sel_in), .case_out(case_out), .case_dflt(case_dflt),
    .dec_in(dec_in), .dec_match(dec_match));
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [5:0] ex(input logic [7:0] s, input logic [1:0] d);
    logic [3:0] c;
    c = {s == 8'h07, s == 8'h05 || s == 8'hff, s == 8'h04,
      s inside {8'h01, 8'h02, 8'h03}};
    return {c == 4'h0, c, d == 2'h1};
  endfunction
  task automatic dp(input logic [7:0] s, input logic [1:0] d);
    @(posedge aclk);
    nsel <= s;
    ndec <= d;
    ld <= 1'b1;
    dq.push_back(ex(s, d));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] rs);
    bit ad, wd;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bq.push_back({rs, 32'h0});
    ad = 0;
    wd = 0;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready && !ad) begin ad = 1; awvalid <= 1'b0; end
      if (wready && !wd) begin wd = 1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (!bvalid);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    bq.push_back(e);
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
  endtask
  // ****
  // Monitor: pairs each observed result with the oldest expectation.
  // ****
  always @(posedge aclk) begin
    if (bvalid && bq.size() > 0) chk({bresp, 32'h0}, bq.pop_front());
    if (rvalid && bq.size() > 0) chk({rresp, rdata}, bq.pop_front());
    if (dp_vld && dq.size() > 0) chk({case_dflt, case_out, dec_match},
      dq.pop_front());
  end
  initial begin
    #200000;
    mismatches++;
    results();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CVM_OFF_CTRL, {CVM_RESP_OKAY, CVM_WORD_RST});
    rd(8'h14, {CVM_RESP_SLVERR, 32'h0});
    for (int i = 0; i < 12; i++) dp(tv[i], i[1:0]);
    repeat (40) begin
      r = $random(seed);
      dp(r[7:0], r[9:8]);
    end
    dp(8'hff, 2'h1);
    @(posedge aclk);
    ld <= 1'b0;
    wr(CVM_OFF_CTRL, 32'hffff_fffe, CVM_RESP_OKAY);
    rd(CVM_OFF_CTRL, {CVM_RESP_OKAY, 32'h0});
    wr(CVM_OFF_SW_SEL, 32'h1234_56a5, CVM_RESP_OKAY);
    rd(CVM_OFF_SW_SEL, {CVM_RESP_OKAY, 32'ha5});
    wr(CVM_OFF_SW_DEC, 32'hf, CVM_RESP_OKAY);
    rd(CVM_OFF_SW_DEC, {CVM_RESP_OKAY, 32'h3});
    wr(CVM_OFF_CASE_STAT, 32'hf, CVM_RESP_OKAY);
    rd(CVM_OFF_CASE_STAT, {CVM_RESP_OKAY, 32'h4});
    rd(CVM_OFF_MISC_STAT, {CVM_RESP_OKAY, 32'h2});
    wr(8'h40, 32'h1, CVM_RESP_SLVERR);
    repeat (3) @(posedge aclk);
    results();
  end
endmodule // tb_top
bind cvm_case_decoder cvm_chk #(.NUM_CASES(NUM_CASES), .SEL_L(SEL_L),
  .DEC_W(DEC_W)) u_chk (.aclk(aclk), .aresetn(aresetn), .sel_in(sel_in),
  .case_out(case_out), .case_dflt(case_dflt), .dec_in(dec_in),
  .dec_match(dec_match));
